// *** src/asg_pkg.sv ***
// constants, encodings and register map of the ats stream gate
package asg_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CAPS = 8'h04;
  localparam logic [7:0] OFF_EVENTS = 8'h08;
  localparam logic [7:0] OFF_LAST = 8'h0c;
  localparam logic [7:0] OFF_CNT_TREQ = 8'h10;
  localparam logic [7:0] OFF_CNT_FORBID = 8'h14;
  localparam logic [7:0] OFF_CNT_BADENT = 8'h18;
  localparam logic [2:0] ENTRY_PAGE = 3'h2;

  // stream table geometry
  localparam int unsigned NUM_ENTRIES = 8;
  localparam int unsigned ID_W = 3;
  localparam int unsigned ENT_W = 10;
  localparam int unsigned CNT_W = 16;

  // control register fields
  localparam int unsigned CTL_CHECK_BIT = 0;
  localparam int unsigned CTL_REV30_BIT = 1;
  localparam logic [1:0] CONTROL_RST = 2'h0;

  // capability register fields
  localparam int unsigned CAP_ATS_BIT = 0;
  localparam int unsigned CAP_NO_STAGE1_ATS_CAPABILITY_BIT = 1;
  localparam int unsigned CAP_DPT_NS_BIT = 2;
  localparam int unsigned CAP_DPT_REALM_BIT = 3;
  localparam logic [3:0] CAPS_RST = 4'h1;

  // stream table entry fields
  localparam int unsigned ENT_FIELD_LSB = 0;
  localparam int unsigned ENT_CFG_LSB = 2;
  localparam int unsigned ENT_S2S_BIT = 5;
  localparam int unsigned ENT_STAGE1_STALL_DISABLE_BIT = 6;
  localparam int unsigned ENT_SEC_LSB = 7;
  localparam int unsigned ENT_EL1_BIT = 9;
  localparam logic [ENT_W-1:0] ENTRY_RST = 10'h000;

  // ats enable field encodings
  localparam logic [1:0] ATS_DISABLED = 2'h0;
  localparam logic [1:0] ATS_FULL = 2'h1;
  localparam logic [1:0] ATS_SPLIT = 2'h2;
  localparam logic [1:0] ATS_DPT = 2'h3;

  // stream configurations
  localparam logic [2:0] CFG_ABORT = 3'h0;
  localparam logic [2:0] CFG_NESTED = 3'h7;

  // security state of the table that holds an entry
  localparam logic [1:0] SEC_NS = 2'h0;
  localparam logic [1:0] SEC_SECURE = 2'h1;
  localparam logic [1:0] SEC_REALM = 2'h2;

  // event codes and sticky flag positions
  localparam logic [1:0] EVT_NONE = 2'h0;
  localparam logic [1:0] EVT_BAD_TREQ = 2'h1;
  localparam logic [1:0] EVT_FORBIDDEN = 2'h2;
  localparam logic [1:0] EVT_BAD_ENTRY = 2'h3;
  localparam int unsigned EVF_TREQ_BIT = 0;
  localparam int unsigned EVF_FORBID_BIT = 1;
  localparam int unsigned EVF_BADENT_BIT = 2;
  localparam logic [2:0] EVENTS_RST = 3'h0;

endpackage

// *** src/asg_entry_decode.sv ***
// combinational decode of one stream entry against one request
`timescale 1ns/1ps
module asg_entry_decode
  import asg_pkg::*;
(
  // entry fields
  input wire logic [1:0] atsEnableField,
  input wire logic [2:0] streamConfig,
  input wire logic stage2StallSelect,
  input wire logic stage1StallDisable,
  input wire logic [1:0] securityState,
  input wire logic worldIsEl1,
  // capabilities and control
  input wire logic atsSupported,
  input wire logic noStage1AtsCapability,
  input wire logic dptSupportNs,
  input wire logic dptSupportRealm,
  input wire logic translatedCheckEnable,
  input wire logic rev30Mode,
  // request kind
  input wire logic isTranslationRequest,
  // outcome
  output logic accept,
  output logic abortTxn,
  output logic unsupportedResp,
  output logic returnIpa,
  output logic stage2Only,
  output logic granuleCheck,
  output logic badTreqEvent,
  output logic forbiddenEvent,
  output logic badEntryError,
  output logic [1:0] effField,
  output logic stage1StallDisableEff
);

  // entry classification
  wire isSecure = (securityState == SEC_SECURE);
  wire isNonSecure = (securityState != SEC_SECURE) & (securityState != SEC_REALM);
  wire dptCap = (securityState == SEC_REALM) ? dptSupportRealm : dptSupportNs;
  wire streamOff = (streamConfig == CFG_ABORT);
  wire cfgNoTranslate = (streamConfig[1:0] == 2'h0);
  wire chk = translatedCheckEnable;
  wire fieldIgnored = !atsSupported | cfgNoTranslate | isSecure;
  wire s2Stalling = (streamConfig[2:1] == 2'h3) & stage2StallSelect;

  // legality per encoding; older revision also checks stage2 bypass configs
  wire illegalFull = rev30Mode ? (streamConfig[2] & stage2StallSelect) : s2Stalling;
  wire illegalSplit = (streamConfig != CFG_NESTED) | stage2StallSelect | noStage1AtsCapability;
  wire illegalDpt = dptCap & (!worldIsEl1 | s2Stalling);
  wire illegalSel = (atsEnableField == ATS_FULL) ? illegalFull :
                    (atsEnableField == ATS_SPLIT) ? illegalSplit :
                    (atsEnableField == ATS_DPT) ? illegalDpt : 1'h0;
  wire illegal = !fieldIgnored & illegalSel;

  // effective field value
  wire splitOff = (atsEnableField == ATS_SPLIT) & !chk;
  wire dptOff = (atsEnableField == ATS_DPT) & (!dptCap | (isNonSecure & !chk));
  assign effField = (fieldIgnored | illegal | splitOff | dptOff) ? ATS_DISABLED : atsEnableField;
  wire effNone = (effField == ATS_DISABLED);

  // outcome; silent paths record no fault
  wire silentPath = !atsSupported | streamOff | illegal;
  wire treqUr = isTranslationRequest & (silentPath | effNone);
  wire tranAbort = !isTranslationRequest &
                   (!atsSupported | illegal | (chk & (streamOff | effNone)));
  assign unsupportedResp = treqUr;
  assign abortTxn = tranAbort;
  assign accept = isTranslationRequest ? !treqUr : !tranAbort;
  assign badTreqEvent = treqUr & !silentPath;
  assign forbiddenEvent = tranAbort & !silentPath;
  assign badEntryError = illegal;
  assign returnIpa = isTranslationRequest & accept & (effField == ATS_SPLIT);
  assign stage2Only = !isTranslationRequest & accept & chk & (effField == ATS_SPLIT);
  assign granuleCheck = !isTranslationRequest & accept & chk & (effField == ATS_DPT);
  assign stage1StallDisableEff = streamConfig[0] & stage1StallDisable;

endmodule

// *** src/asg_gate_top.sv ***
// ats stream gate: apb registers, stream table and registered decode stage
`timescale 1ns/1ps
module asg_gate_top
  import asg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request from the root complex side
  input wire logic reqValid,
  input wire logic reqTranslationRequest,
  input wire logic [ID_W-1:0] reqStreamId,
  input wire logic [7:0] reqTag,
  // decision towards the translation pipeline and event recorder
  output logic rspValid,
  output logic [7:0] rspTag,
  output logic [ID_W-1:0] rspStreamId,
  output logic rspTranslationRequest,
  output logic rspAccept,
  output logic rspAbort,
  output logic rspUnsupported,
  output logic rspReturnIpa,
  output logic rspStage2Only,
  output logic rspGranuleCheck,
  output logic rspBadTreqFault,
  output logic rspForbiddenFault,
  output logic rspBadEntryError,
  output logic [1:0] rspEffField,
  output logic rspStage1StallDisable
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge for apb writes
  function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal, input logic [31:0] newVal,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // saturating event counter step; a software clear still counts a same-cycle event
  function automatic logic [CNT_W-1:0] countStep(input logic [CNT_W-1:0] cnt, input logic hit,
                                                 input logic clr);
    logic [CNT_W-1:0] base;
    base = clr ? {CNT_W{1'h0}} : cnt;
    if (hit && (base != {CNT_W{1'h1}}))
    begin
      base = base + {{(CNT_W-1){1'h0}}, 1'h1};
    end
    return base;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb access decode

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [1:0] control_q;
  logic [3:0] caps_q;
  logic [2:0] events_q;
  logic [2:0] events_d;
  logic [ID_W+3:0] last_q;
  logic [CNT_W-1:0] cntTreq_q;
  logic [CNT_W-1:0] cntForbid_q;
  logic [CNT_W-1:0] cntBadEnt_q;
  logic [ENT_W-1:0] entry_q [NUM_ENTRIES];

  // one wait state so that read data comes from a flop
  wire accessCycle = psel & penable;
  wire firstAccess = accessCycle & !pready_q;
  wire writeFire = accessCycle & pready_q & pwrite;
  wire hitControl = (paddr == OFF_CONTROL);
  wire hitCaps = (paddr == OFF_CAPS);
  wire hitEvents = (paddr == OFF_EVENTS);
  wire hitLast = (paddr == OFF_LAST);
  wire hitCntTreq = (paddr == OFF_CNT_TREQ);
  wire hitCntForbid = (paddr == OFF_CNT_FORBID);
  wire hitCntBadEnt = (paddr == OFF_CNT_BADENT);
  wire hitEntry = (paddr[7:5] == ENTRY_PAGE) & (paddr[1:0] == 2'h0);
  wire [ID_W-1:0] entryIdx = paddr[4:2];
  wire addrMapped = hitControl | hitCaps | hitEvents | hitLast | hitCntTreq | hitCntForbid |
                    hitCntBadEnt | hitEntry;
  // the read-only last-event word refuses writes with an error
  wire writeRefused = pwrite & hitLast;
  wire wrControl = writeFire & hitControl;
  wire wrCaps = writeFire & hitCaps;
  wire wrEvents = writeFire & hitEvents;
  wire wrEntry = writeFire & hitEntry;
  wire clrCntTreq = writeFire & hitCntTreq;
  wire clrCntForbid = writeFire & hitCntForbid;
  wire clrCntBadEnt = writeFire & hitCntBadEnt;
  wire [31:0] wrMerged = mergeLanes(32'h0000_0000, pwdata, pstrb);

  // read multiplexer, unmapped words read zero
  wire [31:0] rdMux = hitControl ? {30'h0, control_q} :
                      hitCaps ? {28'h0, caps_q} :
                      hitEvents ? {29'h0, events_q} :
                      hitLast ? {{(32-ID_W-4){1'h0}}, last_q} :
                      hitCntTreq ? {{(32-CNT_W){1'h0}}, cntTreq_q} :
                      hitCntForbid ? {{(32-CNT_W){1'h0}}, cntForbid_q} :
                      hitCntBadEnt ? {{(32-CNT_W){1'h0}}, cntBadEnt_q} :
                      hitEntry ? {{(32-ENT_W){1'h0}}, entry_q[entryIdx]} : 32'h0000_0000;

  // apb answer flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= firstAccess;
      pslverr_q <= firstAccess & (!addrMapped | writeRefused);
      if (firstAccess)
      begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // software-owned control, capabilities and stream table

  // control and capability words, merged per byte lane
  wire [31:0] controlMerged = mergeLanes({30'h0, control_q}, pwdata, pstrb);
  wire [31:0] capsMerged = mergeLanes({28'h0, caps_q}, pwdata, pstrb);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      control_q <= CONTROL_RST;
      caps_q <= CAPS_RST;
    end
    else
    begin
      if (wrControl)
      begin
        control_q <= controlMerged[1:0];
      end
      if (wrCaps)
      begin
        caps_q <= capsMerged[3:0];
      end
    end
  end

  // stream table entries, one word each
  wire [31:0] entryMerged = mergeLanes({{(32-ENT_W){1'h0}}, entry_q[entryIdx]}, pwdata, pstrb);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        entry_q[i] <= ENTRY_RST;
      end
    end
    else if (wrEntry)
    begin
      entry_q[entryIdx] <= entryMerged[ENT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry lookup and decode

  wire [ENT_W-1:0] curEntry = entry_q[reqStreamId];
  logic decAccept;
  logic decAbort;
  logic decUnsupported;
  logic decReturnIpa;
  logic decStage2Only;
  logic decGranuleCheck;
  logic decBadTreq;
  logic decForbidden;
  logic decBadEntry;
  logic [1:0] decEffField;
  logic decStage1StallDis;

  // the check bit is read live; a change lands on the very next request
  asg_entry_decode u_decode (
    .atsEnableField(curEntry[ENT_FIELD_LSB +: 2]),
    .streamConfig(curEntry[ENT_CFG_LSB +: 3]),
    .stage2StallSelect(curEntry[ENT_S2S_BIT]),
    .stage1StallDisable(curEntry[ENT_STAGE1_STALL_DISABLE_BIT]),
    .securityState(curEntry[ENT_SEC_LSB +: 2]),
    .worldIsEl1(curEntry[ENT_EL1_BIT]),
    .atsSupported(caps_q[CAP_ATS_BIT]),
    .noStage1AtsCapability(caps_q[CAP_NO_STAGE1_ATS_CAPABILITY_BIT]),
    .dptSupportNs(caps_q[CAP_DPT_NS_BIT]),
    .dptSupportRealm(caps_q[CAP_DPT_REALM_BIT]),
    .translatedCheckEnable(control_q[CTL_CHECK_BIT]),
    .rev30Mode(control_q[CTL_REV30_BIT]),
    .isTranslationRequest(reqTranslationRequest),
    .accept(decAccept),
    .abortTxn(decAbort),
    .unsupportedResp(decUnsupported),
    .returnIpa(decReturnIpa),
    .stage2Only(decStage2Only),
    .granuleCheck(decGranuleCheck),
    .badTreqEvent(decBadTreq),
    .forbiddenEvent(decForbidden),
    .badEntryError(decBadEntry),
    .effField(decEffField),
    .stage1StallDisableEff(decStage1StallDis)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered decision stage

  // every outcome leaves one cycle after its request; no back-pressure on requests
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rspValid <= 1'h0;
      rspTag <= 8'h00;
      rspStreamId <= {ID_W{1'h0}};
      rspTranslationRequest <= 1'h0;
      rspAccept <= 1'h0;
      rspAbort <= 1'h0;
      rspUnsupported <= 1'h0;
      rspReturnIpa <= 1'h0;
      rspStage2Only <= 1'h0;
      rspGranuleCheck <= 1'h0;
      rspBadTreqFault <= 1'h0;
      rspForbiddenFault <= 1'h0;
      rspBadEntryError <= 1'h0;
      rspEffField <= ATS_DISABLED;
      rspStage1StallDisable <= 1'h0;
    end
    else
    begin
      rspValid <= reqValid;
      rspTag <= reqTag;
      rspStreamId <= reqStreamId;
      rspTranslationRequest <= reqTranslationRequest;
      rspAccept <= reqValid & decAccept;
      rspAbort <= reqValid & decAbort;
      rspUnsupported <= reqValid & decUnsupported;
      rspReturnIpa <= reqValid & decReturnIpa;
      rspStage2Only <= reqValid & decStage2Only;
      rspGranuleCheck <= reqValid & decGranuleCheck;
      rspBadTreqFault <= reqValid & decBadTreq;
      rspForbiddenFault <= reqValid & decForbidden;
      rspBadEntryError <= reqValid & decBadEntry;
      rspEffField <= decEffField;
      rspStage1StallDisable <= decStage1StallDis;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event bookkeeping

  // a new event outranks a write-one-to-clear in the same cycle
  wire evTreq = reqValid & decBadTreq;
  wire evForbid = reqValid & decForbidden;
  wire evBadEnt = reqValid & decBadEntry;
  wire [2:0] evNew = {evBadEnt, evForbid, evTreq};
  wire [2:0] evClear = wrEvents ? wrMerged[2:0] : 3'h0;
  assign events_d = (events_q & ~evClear) | evNew;
  wire [1:0] evCode = evBadEnt ? EVT_BAD_ENTRY : evForbid ? EVT_FORBIDDEN :
                      evTreq ? EVT_BAD_TREQ : EVT_NONE;

  // sticky flags and the record of the latest event
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      events_q <= EVENTS_RST;
      last_q <= {(ID_W+4){1'h0}};
    end
    else
    begin
      events_q <= events_d;
      if (evCode != EVT_NONE)
      begin
        last_q <= {decEffField, reqStreamId, evCode};
      end
    end
  end

  // saturating counters; any write clears one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cntTreq_q <= {CNT_W{1'h0}};
      cntForbid_q <= {CNT_W{1'h0}};
      cntBadEnt_q <= {CNT_W{1'h0}};
    end
    else
    begin
      cntTreq_q <= countStep(cntTreq_q, evTreq, clrCntTreq);
      cntForbid_q <= countStep(cntForbid_q, evForbid, clrCntForbid);
      cntBadEnt_q <= countStep(cntBadEnt_q, evBadEnt, clrCntBadEnt);
    end
  end

endmodule

// *** tb/asg_gate_chk.sv ***
// port assertions of the ats stream gate
`timescale 1ns/1ps
module asg_gate_chk
  import asg_pkg::*;
(
  // clock, reset and apb handshake
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // request side
  input wire logic reqValid,
  input wire logic reqTranslationRequest,
  input wire logic [7:0] reqTag,
  // decision side
  input wire logic rspValid,
  input wire logic [7:0] rspTag,
  input wire logic rspTranslationRequest,
  input wire logic rspAccept,
  input wire logic rspAbort,
  input wire logic rspUnsupported,
  input wire logic rspReturnIpa,
  input wire logic rspStage2Only,
  input wire logic rspGranuleCheck,
  input wire logic rspBadTreqFault,
  input wire logic rspForbiddenFault,
  input wire logic rspBadEntryError,
  input wire logic [1:0] rspEffField
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // timing of the decision stage and of the apb wait state
  AST_RSP_LATENCY: assert property (
    reqValid |=> rspValid && rspTag == $past(reqTag) && rspTranslationRequest == $past(reqTranslationRequest))
    else $error("decision not one cycle after its request");
  AST_RSP_QUIET: assert property (
    !reqValid |=> !rspValid && !(rspAccept || rspAbort || rspUnsupported || rspBadTreqFault || rspBadEntryError))
    else $error("decision bits without a request");
  AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  ////////////////////////////////////////////////////////////////////////////////
  // consistency of one decision
  AST_TRANSLATED_ONE: assert property (
    rspValid && !rspTranslationRequest |-> (rspAccept ^ rspAbort) && !rspUnsupported)
    else $error("translated traffic neither passed nor aborted");
  AST_TREQ_ONE: assert property (
    rspValid && rspTranslationRequest |-> (rspAccept ^ rspUnsupported) && !rspAbort && !rspForbiddenFault)
    else $error("request neither served nor refused");
  AST_BAD_TREQ: assert property (rspBadTreqFault |-> rspUnsupported && rspEffField == 2'h0 && !rspBadEntryError)
    else $error("bad request fault without refusal");
  AST_ZERO_REFUSES: assert property (rspValid && rspTranslationRequest && rspAccept |-> rspEffField != 2'h0)
    else $error("request served with field zero");
  AST_FORBIDDEN: assert property (rspForbiddenFault |-> rspAbort && !rspTranslationRequest && rspEffField == 2'h0)
    else $error("forbidden fault without abort");
  AST_SPLIT_IPA: assert property (rspReturnIpa |-> rspAccept && rspTranslationRequest && rspEffField == 2'h2)
    else $error("stage one address outside split mode");
  AST_SPLIT_S2: assert property (rspStage2Only |-> rspAccept && !rspTranslationRequest && rspEffField == 2'h2)
    else $error("stage two only outside split mode");
  AST_GRANULE: assert property (rspGranuleCheck |-> rspAccept && !rspTranslationRequest && rspEffField == 2'h3)
    else $error("granule check outside encoding three");
  AST_BAD_ENTRY: assert property (rspBadEntryError |-> !rspAccept && rspEffField == 2'h0 && !rspBadTreqFault)
    else $error("illegal entry still served");
endmodule
bind asg_gate_top asg_gate_chk asg_gate_chk_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pready(pready), .reqValid(reqValid), .reqTranslationRequest(reqTranslationRequest), .reqTag(reqTag),
  .rspValid(rspValid), .rspTag(rspTag), .rspTranslationRequest(rspTranslationRequest), .rspAccept(rspAccept),
  .rspAbort(rspAbort), .rspUnsupported(rspUnsupported), .rspReturnIpa(rspReturnIpa),
  .rspStage2Only(rspStage2Only), .rspGranuleCheck(rspGranuleCheck), .rspBadTreqFault(rspBadTreqFault),
  .rspForbiddenFault(rspForbiddenFault), .rspBadEntryError(rspBadEntryError), .rspEffField(rspEffField));

// *** tb/asg_rc_model.sv ***
// root complex model issuing translation requests and translated traffic
`timescale 1ns/1ps
module asg_rc_model
  import asg_pkg::*;
(
  // clock
  input wire logic clk,
  // request towards the gate
  output logic reqValid,
  output logic reqTranslationRequest,
  output logic [ID_W-1:0] reqStreamId,
  output logic [7:0] reqTag
);
  logic busy = 1'b0;
  initial reqValid = 1'b0;
  initial reqTranslationRequest = 1'b0;
  initial reqStreamId = 3'h0;
  initial reqTag = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // qualifiers mean nothing while idle, so they keep moving to expose stale use
  always @(posedge clk)
  begin
    if (!busy)
    begin
      reqTranslationRequest <= ~reqTranslationRequest;
      reqStreamId <= reqStreamId + 3'h3;
      reqTag <= ~reqTag;
    end
  end
  // one request lasts one cycle; the qualifiers stay put while it is in flight
  task automatic send(input logic tr, input logic [ID_W-1:0] id, input logic [7:0] tag);
    busy = 1'b1;
    @(posedge clk);
    reqValid <= 1'b1;
    reqTranslationRequest <= tr;
    reqStreamId <= id;
    reqTag <= tag;
    @(posedge clk);
    reqValid <= 1'b0;
    busy = 1'b0;
  endtask
endmodule

// *** tb/test_ats_stream_gate_decode.sv ***
// self-checking bench of the ats stream gate
`timescale 1ns/1ps
module test_ats_stream_gate_decode;
  import asg_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rdErr;
  logic [7:0] paddr, tagSeq, reqTag, rspTag;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0] pstrb;
  logic reqValid, reqTranslationRequest, rspValid, rspTranslationRequest, rspAccept, rspAbort, rspUnsupported;
  logic rspReturnIpa, rspStage2Only, rspGranuleCheck, rspBadTreqFault, rspForbiddenFault, rspBadEntryError;
  logic rspStage1StallDisable;
  logic [ID_W-1:0] reqStreamId, rspStreamId;
  logic [1:0] rspEffField;
  int error_cnt = 0;
  int n_compared = 0;
  // outcome bits: accept abort refuse ipa stage2 granule badreq forbidden badentry
  localparam logic [8:0] ACC = 9'h100, ACC_IPA = 9'h120, ACC_S2 = 9'h110, ACC_GR = 9'h108;
  localparam logic [8:0] UR_F = 9'h044, ABT_F = 9'h082, UR_S = 9'h040, ABT_S = 9'h080, UR_E = 9'h041;
  ////////////////////////////////////////////////////////////////////////////////
  asg_gate_top asg_gate_top_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reqValid(reqValid), .reqTranslationRequest(reqTranslationRequest), .reqStreamId(reqStreamId),
    .reqTag(reqTag), .rspValid(rspValid), .rspTag(rspTag), .rspStreamId(rspStreamId),
    .rspTranslationRequest(rspTranslationRequest), .rspAccept(rspAccept), .rspAbort(rspAbort),
    .rspUnsupported(rspUnsupported), .rspReturnIpa(rspReturnIpa), .rspStage2Only(rspStage2Only),
    .rspGranuleCheck(rspGranuleCheck), .rspBadTreqFault(rspBadTreqFault), .rspForbiddenFault(rspForbiddenFault),
    .rspBadEntryError(rspBadEntryError), .rspEffField(rspEffField), .rspStage1StallDisable(rspStage1StallDisable));
  asg_rc_model asg_rc_model_i (.clk(clk), .reqValid(reqValid), .reqTranslationRequest(reqTranslationRequest),
    .reqStreamId(reqStreamId), .reqTag(reqTag));
  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; the slave sets the pace, one wait state expected
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    chk(33'(n), 33'h2);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({32'h0, rdErr}, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0);
    chk({rdErr, rdData}, e);
  endtask
  function automatic logic [31:0] ent(int f, int c, int s2, int sc, int el, int sd);
    return 32'(f + c * 4 + s2 * 32 + sd * 64 + sc * 128 + el * 512);
  endfunction
  // one request, judged in the single cycle its decision stands
  task automatic req(input int id, input int tr, input logic [8:0] eo, input int ee);
    tagSeq = tagSeq + 8'h01;
    asg_rc_model_i.send(1'(tr), 3'(id), tagSeq);
    #1;
    chk({10'h0, rspValid, rspTag, rspStreamId, rspAccept, rspAbort, rspUnsupported, rspReturnIpa, rspStage2Only,
      rspGranuleCheck, rspBadTreqFault, rspForbiddenFault, rspBadEntryError, rspEffField},
      {10'h0, 1'b1, tagSeq, 3'(id), eo, 2'(ee)});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_regs();
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h1);
    rd(8'h08, 33'h0);
    rd(8'h40, 33'h0);
    rd(8'h30, 33'h100000000);
    apb(1'b1, 8'h0c, 32'hffffffff);
    chk({32'h0, rdErr}, 33'h1);
    rd(8'h0c, 33'h0);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 33'hf);
    wr(8'h04, 32'h1);
  endtask
  task automatic sc_zero();
    wr(8'h00, 32'h1);
    wr(8'h54, ent(0, 5, 0, 0, 0, 0));
    req(5, 1, UR_F, 0);
    req(5, 0, ABT_F, 0);
    rd(8'h08, 33'h3);
    rd(8'h0c, 33'h16);
    rd(8'h10, 33'h1);
    rd(8'h14, 33'h1);
    wr(8'h08, 32'h3);
    rd(8'h08, 33'h0);
    wr(8'h10, 32'h0);
    rd(8'h10, 33'h0);
    wr(8'h00, 32'h0);
    req(5, 0, ACC, 0);
  endtask
  task automatic sc_full();
    wr(8'h00, 32'h1);
    wr(8'h44, ent(1, 7, 0, 0, 0, 1));
    req(1, 1, ACC, 1);
    chk({32'h0, rspStage1StallDisable}, 33'h1);
    req(1, 0, ACC, 1);
    wr(8'h00, 32'h0);
    req(1, 0, ACC, 1);
    wr(8'h44, ent(1, 6, 1, 0, 0, 1));
    req(1, 1, UR_E, 0);
    wr(8'h44, ent(1, 6, 0, 0, 0, 1));
    req(1, 1, ACC, 1);
    chk({32'h0, rspStage1StallDisable}, 33'h0);
    wr(8'h44, ent(1, 5, 1, 0, 0, 0));
    req(1, 1, ACC, 1);
    wr(8'h00, 32'h2);
    req(1, 1, UR_E, 0);
  endtask
  task automatic sc_split();
    wr(8'h00, 32'h1);
    wr(8'h48, ent(2, 7, 0, 0, 0, 0));
    req(2, 1, ACC_IPA, 2);
    req(2, 0, ACC_S2, 2);
    wr(8'h00, 32'h0);
    req(2, 1, UR_F, 0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h3);
    req(2, 1, UR_E, 0);
    wr(8'h04, 32'h1);
    wr(8'h48, ent(2, 5, 0, 0, 0, 0));
    req(2, 1, UR_E, 0);
    wr(8'h48, ent(2, 7, 1, 0, 0, 0));
    req(2, 1, UR_E, 0);
  endtask
  task automatic sc_perm();
    wr(8'h00, 32'h1);
    wr(8'h4c, ent(3, 5, 0, 0, 1, 0));
    req(3, 1, UR_F, 0);
    wr(8'h04, 32'h5);
    wr(8'h4c, ent(3, 5, 0, 2, 1, 0));
    req(3, 1, UR_F, 0);
    wr(8'h4c, ent(3, 5, 0, 0, 0, 0));
    req(3, 1, UR_E, 0);
    wr(8'h4c, ent(3, 6, 1, 0, 1, 0));
    req(3, 1, UR_E, 0);
    wr(8'h4c, ent(3, 5, 0, 0, 1, 0));
    req(3, 1, ACC, 3);
    req(3, 0, ACC_GR, 3);
    wr(8'h00, 32'h0);
    req(3, 1, UR_F, 0);
    wr(8'h04, 32'h9);
    wr(8'h4c, ent(3, 5, 0, 2, 1, 0));
    req(3, 1, ACC, 3);
  endtask
  task automatic sc_gated();
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h1);
    wr(8'h50, ent(1, 5, 0, 1, 0, 0));
    req(4, 1, UR_F, 0);
    wr(8'h50, ent(1, 4, 0, 0, 0, 0));
    req(4, 1, UR_F, 0);
    req(4, 0, ABT_F, 0);
    wr(8'h50, ent(1, 0, 0, 0, 0, 0));
    req(4, 1, UR_S, 0);
    req(4, 0, ABT_S, 0);
    wr(8'h00, 32'h0);
    req(4, 0, ACC, 0);
    wr(8'h50, ent(1, 5, 0, 0, 0, 0));
    wr(8'h04, 32'h0);
    req(4, 1, UR_S, 0);
    req(4, 0, ABT_S, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    tagSeq = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    sc_regs();
    sc_zero();
    sc_full();
    sc_split();
    sc_perm();
    sc_gated();
    complete_run();
  end
endmodule
